/* File: verilog/wdc_pkg.sv */
// Constants and types shared by the watchdog down counter.
// Assumes one 20 MHz clock; registers are reached by index over APB.
package wdc_pkg;

  // Counter width
  localparam int unsigned CNT_W = 14;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_FSEL    = 6'h30;
  localparam logic [5:0] IDX_REFRESH = 6'h31;
  localparam logic [5:0] IDX_START   = 6'h32;
  localparam logic [5:0] IDX_CTRL    = 6'h33;
  localparam logic [5:0] IDX_PROT    = 6'h34;
  localparam logic [5:0] IDX_PIC     = 6'h35;

  // Field positions
  localparam int unsigned FSEL_FLAG_BIT = 6;
  localparam int unsigned FSEL_RSEL_BIT = 7;
  localparam int unsigned CTRL_SRC_LSB  = 6;
  localparam int unsigned PROT_EN_BIT   = 7;

  // Values after reset
  localparam logic [1:0] CTRL_SRC_RST = 2'h1;
  localparam logic [7:0] PIC_RST      = 8'h00;

  // Refresh sequence bytes
  localparam logic [7:0] REFRESH_ARM  = 8'h00;
  localparam logic [7:0] REFRESH_FIRE = 8'hFF;

  // Count source dividers
  localparam int unsigned PRE_W     = 7;
  localparam logic [3:0]  LOCO_LAST = 4'hF;

  // Counter reload values per initial value selection
  localparam logic [13:0] INIT_VAL0 = 14'h03FF;
  localparam logic [13:0] INIT_VAL1 = 14'h0FFF;
  localparam logic [13:0] INIT_VAL2 = 14'h1FFF;
  localparam logic [13:0] INIT_VAL3 = 14'h3FFF;

  // Option setting bits, held in nonvolatile storage outside
  typedef struct packed {
    logic       start_at_reset_opt;
    logic       protection_at_reset_opt;
    logic [1:0] initial_value_sel;
    logic [1:0] accept_window_sel;
  } wdc_opt_t;

  // Counter run state
  typedef enum logic [1:0] {
    WDC_ST_STOP = 2'b01,
    WDC_ST_RUN  = 2'b10
  } wdc_state_t;

  // Count source selection
  typedef enum logic [1:0] {
    SRC_CPU_DIV2   = 2'b00,
    SRC_CPU_DIV16  = 2'b01,
    SRC_CPU_DIV128 = 2'b10,
    SRC_LOCO_DIV16 = 2'b11
  } wdc_src_t;

endpackage

/* File: verilog/wdc_top.sv */
// Watchdog down counter with APB register access.
// Assumes all inputs synchronous to clk; loco_tick is one pulse per oscillator edge.
//
// The APB register port was decided locally.
module wdc_top (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Option bytes and clock system
  input  wire wdc_pkg::wdc_opt_t opt,
  input  wire logic             cpu_halted,
  input  wire logic             loco_tick,
  // Watchdog requests
  output logic                  wdt_irq,
  output logic                  wdt_reset_req
);

  wdc_pkg::wdc_state_t state_r, state_nxt;
  wdc_pkg::wdc_opt_t   opt_r, opt_nxt;
  logic [13:0]         cnt_r, cnt_nxt;
  logic [6:0]          pre_r, pre_nxt;
  logic [3:0]          loco_r, loco_nxt;
  logic [1:0]          src_r, src_nxt;
  logic [7:0]          pic_r, pic_nxt;
  logic [31:0]         rd_r, rd_nxt;
  logic                err_r, err_nxt;
  logic                armed_r, armed_nxt;
  logic                flag_r, flag_nxt;
  logic                rsel_r, rsel_nxt;
  logic                prot_r, prot_nxt;
  logic                irq_r, irq_nxt;
  logic                rst_r, rst_nxt;
  logic                wr, setup, src_cpu, halt, cpu_edge, src_edge, tick;
  logic                refresh_seq, in_window, refresh_ok, illegal, underflow;
  logic                rsel_eff, evt_irq, evt_rst, mapped;
  logic [5:0]          idx;
  logic [13:0]         reload, thr;

  // Reload value for a given option selection
  function automatic logic [13:0] init_of(input logic [1:0] sel);
    case (sel)
      2'b00:   init_of = wdc_pkg::INIT_VAL0;
      2'b01:   init_of = wdc_pkg::INIT_VAL1;
      2'b10:   init_of = wdc_pkg::INIT_VAL2;
      default: init_of = wdc_pkg::INIT_VAL3;
    endcase
  endfunction

  // Bus decode; zero wait states, read data snapped in the setup cycle
  assign idx     = paddr[7:2];
  assign wr      = psel & penable & pwrite;
  assign setup   = psel & ~penable;
  assign pready  = 1'b1;
  assign prdata  = rd_r;
  assign pslverr = err_r;
  assign mapped  = (idx >= wdc_pkg::IDX_FSEL) && (idx <= wdc_pkg::IDX_PIC) &&
                   (paddr[1:0] == 2'b00);

  // Count source selection and gating
  always_comb begin
    src_cpu = (src_r != wdc_pkg::SRC_LOCO_DIV16);
    halt    = cpu_halted & src_cpu & ~prot_r;
    case (src_r)
      wdc_pkg::SRC_CPU_DIV2:   cpu_edge = pre_r[0];
      wdc_pkg::SRC_CPU_DIV16:  cpu_edge = &pre_r[3:0];
      wdc_pkg::SRC_CPU_DIV128: cpu_edge = &pre_r;
      default:                 cpu_edge = 1'b0;
    endcase
    src_edge = src_cpu ? (cpu_edge & ~halt)
                       : (loco_tick & (loco_r == wdc_pkg::LOCO_LAST));
    tick     = src_edge & (state_r == wdc_pkg::WDC_ST_RUN);
  end

  // Window and refresh decode
  always_comb begin
    reload = init_of(opt_r.initial_value_sel);
    case (opt_r.accept_window_sel)
      2'b00:   thr = reload >> 2;
      2'b01:   thr = reload >> 1;
      2'b10:   thr = reload - (reload >> 2);
      default: thr = reload;
    endcase
    in_window   = (cnt_r <= thr);
    refresh_seq = wr & (idx == wdc_pkg::IDX_REFRESH) & armed_r &
                  (pwdata[7:0] == wdc_pkg::REFRESH_FIRE) &
                  (state_r == wdc_pkg::WDC_ST_RUN);
    refresh_ok  = refresh_seq & in_window;
    illegal     = refresh_seq & ~in_window;
    underflow   = tick & (cnt_r == 14'h0000);
    rsel_eff    = rsel_r | prot_r;
    evt_irq     = (underflow | illegal) & ~rsel_eff;
    evt_rst     = (underflow | illegal) & rsel_eff;
  end

  // Counter, dividers and run state
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    pre_nxt   = halt ? pre_r : pre_r + 7'h01;                    // CPU clock stops in wait
    loco_nxt  = loco_tick ? loco_r + 4'h1 : loco_r;
    opt_nxt   = opt_r;
    case (state_r)
      wdc_pkg::WDC_ST_STOP: begin
        if (wr && idx == wdc_pkg::IDX_START) begin
          state_nxt = wdc_pkg::WDC_ST_RUN;
        end
      end
      wdc_pkg::WDC_ST_RUN: state_nxt = wdc_pkg::WDC_ST_RUN;
      default: state_nxt = wdc_pkg::WDC_ST_STOP;
    endcase
    // Illegal refresh in interrupt mode does not reload; the count still decrements on a tick
    if (refresh_ok || underflow || (illegal && rsel_eff)) begin
      cnt_nxt = reload;
    end else if (tick) begin
      cnt_nxt = cnt_r - 14'h0001;
    end
    if (!rst_n) begin
      opt_nxt   = opt;
      cnt_nxt   = init_of(opt.initial_value_sel);
      pre_nxt   = 7'h00;
      loco_nxt  = 4'h0;
      state_nxt = opt.start_at_reset_opt ? wdc_pkg::WDC_ST_RUN
                                         : wdc_pkg::WDC_ST_STOP;
    end
  end

  always_ff @(posedge clk) begin
    state_r <= state_nxt;
    cnt_r   <= cnt_nxt;
    pre_r   <= pre_nxt;
    loco_r  <= loco_nxt;
    opt_r   <= opt_nxt;
  end

  // Software-visible control and status
  always_comb begin
    armed_nxt = armed_r;
    flag_nxt  = flag_r;
    rsel_nxt  = rsel_r | prot_r;
    prot_nxt  = prot_r;
    src_nxt   = src_r;
    pic_nxt   = pic_r;
    if (wr && idx == wdc_pkg::IDX_REFRESH) begin
      armed_nxt = (pwdata[7:0] == wdc_pkg::REFRESH_ARM);
    end
    if (wr && idx == wdc_pkg::IDX_FSEL) begin
      if (!pwdata[wdc_pkg::FSEL_FLAG_BIT]) begin
        flag_nxt = 1'b0;
      end
      if (pwdata[wdc_pkg::FSEL_RSEL_BIT]) begin
        rsel_nxt = 1'b1;
      end
    end
    if (evt_irq) begin
      flag_nxt = 1'b1;                                           // set beats clear
    end
    if (wr && idx == wdc_pkg::IDX_CTRL) begin
      src_nxt = pwdata[wdc_pkg::CTRL_SRC_LSB +: 2];
    end
    // Locked once the option enabled protection at reset
    if (wr && idx == wdc_pkg::IDX_PROT && !opt_r.protection_at_reset_opt) begin
      prot_nxt = pwdata[wdc_pkg::PROT_EN_BIT];
    end
    if (wr && idx == wdc_pkg::IDX_PIC) begin
      pic_nxt = pwdata[7:0];
    end
    if (!rst_n) begin
      armed_nxt = 1'b0;
      flag_nxt  = 1'b0;
      rsel_nxt  = opt.protection_at_reset_opt;
      prot_nxt  = opt.protection_at_reset_opt;
      src_nxt   = wdc_pkg::CTRL_SRC_RST;
      pic_nxt   = wdc_pkg::PIC_RST;
    end
  end

  always_ff @(posedge clk) begin
    armed_r <= armed_nxt;
    flag_r  <= flag_nxt;
    rsel_r  <= rsel_nxt;
    prot_r  <= prot_nxt;
    src_r   <= src_nxt;
    pic_r   <= pic_nxt;
  end

  // Requests stand until the next count source edge
  always_comb begin
    irq_nxt = evt_irq ? 1'b1 : (src_edge ? 1'b0 : irq_r);
    rst_nxt = evt_rst ? 1'b1 : (src_edge ? 1'b0 : rst_r);
    if (!rst_n) begin
      irq_nxt = 1'b0;
      rst_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    irq_r <= irq_nxt;
    rst_r <= rst_nxt;
  end

  assign wdt_irq       = irq_r;
  assign wdt_reset_req = rst_r;

  // Read mux; write-only registers read as zero
  always_comb begin
    rd_nxt  = rd_r;
    err_nxt = err_r;
    if (setup) begin
      err_nxt = ~mapped;
      case (idx)
        wdc_pkg::IDX_FSEL: rd_nxt = {24'h000000, rsel_r, flag_r, 6'h00};
        wdc_pkg::IDX_CTRL: rd_nxt = {24'h000000, src_r, cnt_r[13:8]};
        wdc_pkg::IDX_PROT: rd_nxt = {24'h000000, prot_r, 7'h00};
        wdc_pkg::IDX_PIC:  rd_nxt = {24'h000000, pic_r};
        default:           rd_nxt = 32'h00000000;
      endcase
    end
    if (!rst_n) begin
      rd_nxt  = 32'h00000000;
      err_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    rd_r  <= rd_nxt;
    err_r <= err_nxt;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_refresh;
    refresh_seq ##0 in_window;
  endsequence

  sequence s_wrap;
    tick ##0 (cnt_r == 14'h0000);
  endsequence

  cnt_decrement_a: assert property (
    (tick && cnt_r != 14'h0000 && !refresh_seq) |=> cnt_r == $past(cnt_r) - 14'h0001)
    else $error("counter did not decrement by one");

  halt_freeze_a: assert property (
    (cpu_halted && src_cpu && !prot_r && !refresh_seq) |=> $stable(cnt_r))
    else $error("count ran while halted");

  start_write_a: assert property (
    (state_r == wdc_pkg::WDC_ST_STOP && wr && idx == wdc_pkg::IDX_START)
      |=> state_r == wdc_pkg::WDC_ST_RUN)
    else $error("start write did not start counter");

  refresh_reload_a: assert property (
    s_refresh |=> cnt_r == reload)
    else $error("refresh did not reload");

  wrap_irq_a: assert property (
    s_wrap ##0 !rsel_eff |=> wdt_irq && !wdt_reset_req && cnt_r == reload)
    else $error("underflow interrupt missing");

  wrap_rst_a: assert property (
    s_wrap ##0 rsel_eff |=> wdt_reset_req && !wdt_irq)
    else $error("underflow reset missing");

  illegal_hold_a: assert property (
    (illegal && !rsel_eff && !tick) |=> flag_r && cnt_r == $past(cnt_r))
    else $error("illegal refresh handled wrongly");

  prot_forces_a: assert property (
    prot_r |=> rsel_r)
    else $error("protection did not force reset select");

  flag_sticky_a: assert property (
    (flag_r && !(wr && idx == wdc_pkg::IDX_FSEL)) |=> flag_r)
    else $error("flag cleared without write");

  req_span_a: assert property (
    (wdt_irq && !src_edge && !evt_irq) |=> wdt_irq)
    else $error("request dropped before source edge");

endmodule // wdc_top

/* File: sim/testbench.sv */
// Self-checking bench for the watchdog down counter.
// Drives APB, option bits and clock-system inputs directly; no partner model.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic              clk, rst_n, psel, penable, pwrite, cpu_halted, loco_tick;
  logic              wdt_irq, wdt_reset_req, pready, pslverr, err;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd, a;
  wdc_pkg::wdc_opt_t opt;
  int                errors, compares, t0, n;
  int                cyc = 0;

  wdc_top u_wdc_top (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .opt(opt), .cpu_halted(cpu_halted), .loco_tick(loco_tick),
    .wdt_irq(wdt_irq), .wdt_reset_req(wdt_reset_req)
  );

  // 20 MHz clock and a free cycle count for timing checks
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task automatic wrap_up;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_span(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'h0};
    pwdata  <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      errors++;
      wrap_up();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, rd, err);
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00, rd, err);
    chk(rd, exp);
  endtask

  // Bounded wait for a request output; running out ends the run
  task automatic wait_req(input bit rq, input int lim);
    n = 0;
    while ((rq ? wdt_reset_req : wdt_irq) !== 1'b1) begin
      if (n == lim) begin
        errors++;
        wrap_up();
      end
      @(posedge clk);
      n++;
    end
  endtask

  // Option bits stay stable while reset is low
  task automatic do_reset(input wdc_pkg::wdc_opt_t o, input int c);
    rst_n <= 1'b0;
    opt   <= o;
    repeat (c) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  function automatic logic [13:0] rl(input logic [1:0] s);
    case (s)
      2'h0:    return wdc_pkg::INIT_VAL0;
      2'h1:    return wdc_pkg::INIT_VAL1;
      2'h2:    return wdc_pkg::INIT_VAL2;
      default: return wdc_pkg::INIT_VAL3;
    endcase
  endfunction

  // Control reads show source select above counter top bits
  function automatic logic [31:0] cx(input logic [1:0] s, input logic [13:0] c);
    return {24'h0, s, c[13:8]};
  endfunction

  // Main sequence; counter values are coarse, only top bits are compared
  initial begin
    {rst_n, psel, penable, pwrite, cpu_halted, loco_tick} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    opt = '0;
    errors = 0;
    compares = 0;
    void'($urandom(32'h7EA2));
    do_reset('{1'b0, 1'b0, 2'h0, 2'h3}, 12);
    rd_chk(wdc_pkg::IDX_FSEL, 32'h00);
    rd_chk(wdc_pkg::IDX_CTRL, cx(2'h1, rl(2'h0)));
    rd_chk(wdc_pkg::IDX_PIC, 32'h00);
    apb(1'b0, 6'h3F, 8'h00, rd, err);
    chk({31'h0, err}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      a = $urandom;
      wr(wdc_pkg::IDX_PIC, a[7:0]);
      rd_chk(wdc_pkg::IDX_PIC, {24'h0, a[7:0]});
    end
    wr(wdc_pkg::IDX_CTRL, 8'h00);
    repeat (600) @(posedge clk);
    rd_chk(wdc_pkg::IDX_CTRL, cx(2'h0, rl(2'h0)));
    wr(wdc_pkg::IDX_START, a[7:0]);
    t0 = cyc;
    repeat (600) @(posedge clk);
    rd_chk(wdc_pkg::IDX_CTRL, cx(2'h0, rl(2'h0) - 14'd300));
    wait_req(1'b0, 2000);
    chk_span(cyc - t0, 2044, 2054);
    n = 0;
    while (wdt_irq === 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    chk_span(n, 2, 2);
    rd_chk(wdc_pkg::IDX_FSEL, 32'h40);
    wr(wdc_pkg::IDX_FSEL, 8'h00);
    rd_chk(wdc_pkg::IDX_FSEL, 32'h00);
    // CPU source stalls while the core sleeps
    cpu_halted <= 1'b1;
    apb(1'b0, wdc_pkg::IDX_CTRL, 8'h00, a, err);
    repeat (600) @(posedge clk);
    rd_chk(wdc_pkg::IDX_CTRL, a);
    cpu_halted <= 1'b0;
    repeat (600) @(posedge clk);
    rd_chk(wdc_pkg::IDX_CTRL, cx(2'h0, rl(2'h0) - 14'd310));
    wr(wdc_pkg::IDX_REFRESH, wdc_pkg::REFRESH_ARM);
    wr(wdc_pkg::IDX_REFRESH, wdc_pkg::REFRESH_FIRE);
    rd_chk(wdc_pkg::IDX_CTRL, cx(2'h0, rl(2'h0)));
    wr(wdc_pkg::IDX_PROT, 8'h80);
    rd_chk(wdc_pkg::IDX_PROT, 32'h80);
    rd_chk(wdc_pkg::IDX_FSEL, 32'h80);
    wr(wdc_pkg::IDX_FSEL, 8'h00);
    rd_chk(wdc_pkg::IDX_FSEL, 32'h80);
    // Protection keeps counting through a halt
    cpu_halted <= 1'b1;
    repeat (600) @(posedge clk);
    rd_chk(wdc_pkg::IDX_CTRL, cx(2'h0, rl(2'h0) - 14'd310));
    wait_req(1'b1, 2000);
    chk({31'h0, wdt_irq}, 32'h0);
    rd_chk(wdc_pkg::IDX_FSEL, 32'h80);
    cpu_halted <= 1'b0;
    wr(wdc_pkg::IDX_PROT, 8'h00);
    rd_chk(wdc_pkg::IDX_PROT, 32'h00);
    // Auto start and a refresh outside the window
    do_reset('{1'b1, 1'b0, 2'h1, 2'h0}, 2);
    rd_chk(wdc_pkg::IDX_CTRL, cx(2'h1, rl(2'h1)));
    repeat (4200) @(posedge clk);
    rd_chk(wdc_pkg::IDX_CTRL, cx(2'h1, rl(2'h1) - 14'd263));
    wr(wdc_pkg::IDX_REFRESH, wdc_pkg::REFRESH_ARM);
    wr(wdc_pkg::IDX_REFRESH, wdc_pkg::REFRESH_FIRE);
    wait_req(1'b0, 40);
    rd_chk(wdc_pkg::IDX_FSEL, 32'h40);
    rd_chk(wdc_pkg::IDX_CTRL, cx(2'h1, rl(2'h1) - 14'd263));
    // Other reload and window options; an early refresh is illegal
    for (int s = 2; s < 4; s++) begin
      do_reset('{1'b1, 1'b0, s[1:0], s[1:0] - 2'h1}, 2);
      rd_chk(wdc_pkg::IDX_CTRL, cx(2'h1, rl(s[1:0])));
      wr(wdc_pkg::IDX_REFRESH, wdc_pkg::REFRESH_ARM);
      wr(wdc_pkg::IDX_REFRESH, wdc_pkg::REFRESH_FIRE);
      wait_req(1'b0, 40);
      rd_chk(wdc_pkg::IDX_FSEL, 32'h40);
    end
    // Protection from the option bit; oscillator source
    do_reset('{1'b0, 1'b1, 2'h0, 2'h3}, 2);
    rd_chk(wdc_pkg::IDX_FSEL, 32'h80);
    wr(wdc_pkg::IDX_PROT, 8'h00);
    rd_chk(wdc_pkg::IDX_PROT, 32'h80);
    wr(wdc_pkg::IDX_CTRL, 8'hC0);
    wr(wdc_pkg::IDX_START, 8'h5A);
    repeat (500) @(posedge clk);
    rd_chk(wdc_pkg::IDX_CTRL, cx(2'h3, rl(2'h0)));
    loco_tick <= 1'b1;
    repeat (4200) @(posedge clk);
    loco_tick <= 1'b0;
    rd_chk(wdc_pkg::IDX_CTRL, cx(2'h3, rl(2'h0) - 14'd262));
    // Slowest CPU divider after a legal refresh
    wr(wdc_pkg::IDX_REFRESH, wdc_pkg::REFRESH_ARM);
    wr(wdc_pkg::IDX_REFRESH, wdc_pkg::REFRESH_FIRE);
    wr(wdc_pkg::IDX_CTRL, 8'h80);
    rd_chk(wdc_pkg::IDX_CTRL, cx(2'h2, rl(2'h0)));
    repeat (40000) @(posedge clk);
    rd_chk(wdc_pkg::IDX_CTRL, cx(2'h2, rl(2'h0) - 14'd312));
    wrap_up();
  end
endmodule // testbench
